// *** core/tpc_clk_sync.sv ***
// Synchronizer and rising-edge detector for the fixed and external clocks
`timescale 1ns/10ps
module tpc_clk_sync
    import tpc_pkg::*;
(
    input  logic aclk,
    input  logic aresetn,
    input  logic ext_clk_in,
    input  logic fixed_clk_in,
    output logic ext_tick,
    output logic fixed_tick
);
    tpc_sync_t r_reg;
    tpc_sync_t r_next;

    // Source must stay below half of aclk or edges are lost
    always_comb begin
        r_next      = r_reg;
        r_next.meta = {ext_clk_in, fixed_clk_in};
        r_next.sync = r_reg.meta;
        r_next.prev = r_reg.sync;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign ext_tick   = r_reg.sync[1] & ~r_reg.prev[1];
    assign fixed_tick = r_reg.sync[0] & ~r_reg.prev[0];

    property p_tick_single;
        @(posedge aclk) disable iff (!aresetn)
        ext_tick |=> !ext_tick;
    endproperty
    a_tick_single: assert property (p_tick_single) else $error("ext tick longer than one cycle");
endmodule

// *** core/tpc_core.sv ***
// Timer core: counter, prescaler, modulo, one channel, AXI4-Lite registers
// Contract
// - Clock source field picks prescaler input
// - Prescaler divides by two to the field
// - Counter byte read latches both bytes
// - Reset or counter/global writes release latch
// - Counter not writable as storage; resets zero
// - Debug freezes counter and read latch
// - At modulo wrap or turn; set overflow
// - Half-written modulo inhibits overflow flag
// - Modulo resets zero meaning free running
// - Capture edge sets channel flag
// - Compare match sets flag in OC/EPWM
// - Center PWM matches up and down flag
// - Channel request is flag and enable
// - Flag cleared by read then zero write
// - New event cancels pending clear
// - Writing one keeps flag; reset clears
// - Mode B selects edge-aligned PWM
// - Mode A selects capture or compare
// - Edge/level 0:0 releases the pin
// - Capture edge codes rise, fall, both
// - Compare codes none, toggle, clear, set
// - PWM polarity from edge/level code
// - Overflow flag read-then-zero clear
`timescale 1ns/10ps
`include "tpc_defs.svh"
module tpc_core
    import tpc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  logic              aclk,
    input  logic              aresetn,
    input  logic [ADDR_W-1:0] awaddr,
    input  logic [2:0]        awprot,
    input  logic              awvalid,
    output logic              awready,
    input  logic [31:0]       wdata,
    input  logic [3:0]        wstrb,
    input  logic              wvalid,
    output logic              wready,
    output logic [1:0]        bresp,
    output logic              bvalid,
    input  logic              bready,
    input  logic [ADDR_W-1:0] araddr,
    input  logic [2:0]        arprot,
    input  logic              arvalid,
    output logic              arready,
    output logic [31:0]       rdata,
    output logic [1:0]        rresp,
    output logic              rvalid,
    input  logic              rready,
    input  logic              bgnd_active,
    input  logic              ext_clk_in,
    input  logic              fixed_clk_in,
    input  logic              ch_pin_in,
    output logic              ch_pin_out,
    output logic              ch_pin_oe,
    output logic              ch_irq,
    output logic              ovf_irq
);
    tpc_state_t  r;
    tpc_state_t  n;
    tpc_mode_t   mode;
    logic        ext_tick;
    logic        fixed_tick;
    logic        src_on;
    logic        src_tick;
    logic [6:0]  pmask;
    logic        tmr_tick;
    logic [15:0] term;
    logic [15:0] cnt_nx;
    logic        down_nx;
    logic        ovf_evt;
    logic        match_evt;
    logic        ic_hit;
    logic        ch_evt;
    logic        wr_fire;
    logic        wr_en;
    logic        rd_fire;
    logic        rd_bad;
    logic [2:0]  rd_idx;
    logic        rd_hi;

    function automatic logic [3:0] tpc_decode(input logic [ADDR_W-1:0] a);
        tpc_decode = {|a[ADDR_W-1:5], a[4:2]};
    endfunction

    function automatic tpc_mode_t tpc_mode(input logic cp, input logic mb, input logic ma);
        if (cp) begin
            tpc_mode = tpc_mode_cpwm;
        end else if (mb) begin
            tpc_mode = tpc_mode_epwm;
        end else if (ma) begin
            tpc_mode = tpc_mode_oc;
        end else begin
            tpc_mode = tpc_mode_ic;
        end
    endfunction

    tpc_clk_sync u_sync (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .ext_clk_in   (ext_clk_in),
        .fixed_clk_in (fixed_clk_in),
        .ext_tick     (ext_tick),
        .fixed_tick   (fixed_tick)
    );

    assign mode      = tpc_mode(r.center_aligned_select, r.msb, r.msa);
    assign awready   = !r.aw_have;
    assign wready    = !r.w_have;
    assign arready   = !r.rvalid;
    assign bvalid    = r.bvalid;
    assign bresp     = r.bresp;
    assign rvalid    = r.rvalid;
    assign rresp     = r.rresp;
    assign rdata     = {24'h000000, r.rdata};
    assign wr_fire   = r.aw_have && r.w_have && !r.bvalid;
    assign wr_en     = wr_fire && !r.aw_bad && r.w_lane;
    assign rd_fire   = arvalid && !r.rvalid;
    assign {rd_bad, rd_idx} = tpc_decode(araddr);
    assign rd_hi     = (rd_idx == `TPC_IDX_CNTH);
    assign ch_irq    = r.chf & r.chie;
    assign ovf_irq   = r.counter_overflow_flag & r.overflow_irq_enable;
    // Pin belongs to the timer only in output-type modes with a code set
    assign ch_pin_oe = (r.els != `TPC_ELS_OFF) && (mode != tpc_mode_ic);
    assign ch_pin_out = r.pin_out;

    // Clock source and prescaler; debug stops every tick
    always_comb begin
        unique case (r.clks)
            `TPC_CLKS_OFF: src_on = 1'b0;
            `TPC_CLKS_BUS: src_on = 1'b1;
            `TPC_CLKS_FIX: src_on = fixed_tick;
            `TPC_CLKS_EXT: src_on = ext_tick;
        endcase
        src_tick = src_on && !bgnd_active;
        pmask    = 7'((8'h01 << r.ps) - 8'h01);
        tmr_tick = src_tick && ((r.pre & pmask) == pmask);
    end

    // Counter step and channel events
    always_comb begin
        term    = (r.mod == `TPC_MOD_RST) ? `TPC_CNT_FULL : r.mod;
        cnt_nx  = r.cnt + 16'h0001;
        down_nx = r.down;
        ovf_evt = 1'b0;
        if (r.center_aligned_select) begin
            if (r.down) begin
                if (r.cnt == `TPC_CNT_ZERO) begin
                    down_nx = 1'b0;
                end else begin
                    cnt_nx = r.cnt - 16'h0001;
                end
            end else if (r.cnt == term) begin
                down_nx = 1'b1;
                cnt_nx  = r.cnt - 16'h0001;
                ovf_evt = tmr_tick;
            end
        end else if (r.cnt == term) begin
            cnt_nx  = `TPC_CNT_ZERO;
            ovf_evt = tmr_tick;
        end
        match_evt = tmr_tick && (cnt_nx == r.chval);
        unique case (r.els)
            `TPC_ELS_OFF:  ic_hit = 1'b0;
            `TPC_ELS_RISE: ic_hit = ch_pin_in & ~r.pin_prev;
            `TPC_ELS_FALL: ic_hit = ~ch_pin_in & r.pin_prev;
            `TPC_ELS_BOTH: ic_hit = ch_pin_in ^ r.pin_prev;
        endcase
        // Both directions count in center mode, so match fires twice
        ch_evt = (mode == tpc_mode_ic) ? ic_hit : match_evt;
    end

    always_comb begin
        n          = r;
        n.pin_prev = ch_pin_in;
        if (src_tick) begin
            n.pre = r.pre + 7'h01;
        end
        if (tmr_tick) begin
            n.cnt  = cnt_nx;
            n.down = down_nx;
        end
        if (awvalid && !r.aw_have) begin
            n.aw_have = 1'b1;
            {n.aw_bad, n.aw_idx} = tpc_decode(awaddr);
        end
        if (wvalid && !r.w_have) begin
            n.w_have = 1'b1;
            n.w_data = wdata[7:0];
            n.w_lane = wstrb[0];
        end
        if (r.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (r.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (wr_fire) begin
            n.aw_have = 1'b0;
            n.w_have  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = r.aw_bad ? `TPC_RESP_SLVERR : `TPC_RESP_OKAY;
        end
        if (wr_en) begin
            unique case (r.aw_idx)
                `TPC_IDX_GSC: begin
                    n.overflow_irq_enable  = r.w_data[`TPC_BIT_IE];
                    n.center_aligned_select = r.w_data[`TPC_BIT_CPWM];
                    n.clks  = r.w_data[`TPC_CLKS_HI:`TPC_CLKS_LO];
                    n.ps    = r.w_data[`TPC_PS_HI:0];
                    n.clat  = 1'b0;
                    n.tof_arm = 1'b0;
                    if (!r.w_data[`TPC_BIT_FLAG] && r.tof_arm) begin
                        n.counter_overflow_flag = 1'b0;
                    end
                end
                `TPC_IDX_CNTH, `TPC_IDX_CNTL: begin
                    // Any write restarts the count instead of storing data
                    n.cnt  = `TPC_CNT_ZERO;
                    n.pre  = 7'h00;
                    n.down = 1'b0;
                    n.clat = 1'b0;
                end
                `TPC_IDX_MODH, `TPC_IDX_MODL: begin
                    if (r.aw_idx == `TPC_IDX_MODH) begin
                        n.mod[15:8] = r.w_data;
                    end else begin
                        n.mod[7:0] = r.w_data;
                    end
                    // Pair closes only when the opposite byte arrives
                    if (r.mod_pend && (r.mod_hi != (r.aw_idx == `TPC_IDX_MODH))) begin
                        n.mod_pend = 1'b0;
                    end else begin
                        n.mod_pend = 1'b1;
                        n.mod_hi   = (r.aw_idx == `TPC_IDX_MODH);
                    end
                end
                `TPC_IDX_CSC: begin
                    n.chie    = r.w_data[`TPC_BIT_IE];
                    n.msb     = r.w_data[`TPC_BIT_MSB];
                    n.msa     = r.w_data[`TPC_BIT_MSA];
                    n.els     = r.w_data[`TPC_ELS_HI:`TPC_ELS_LO];
                    n.chf_arm = 1'b0;
                    if (!r.w_data[`TPC_BIT_FLAG] && r.chf_arm) begin
                        n.chf = 1'b0;
                    end
                end
                `TPC_IDX_CVH: n.chval[15:8] = r.w_data;
                `TPC_IDX_CVL: n.chval[7:0]  = r.w_data;
            endcase
        end
        if (rd_fire) begin
            n.rvalid = 1'b1;
            n.rresp  = rd_bad ? `TPC_RESP_SLVERR : `TPC_RESP_OKAY;
            n.rdata  = 8'h00;
            if (!rd_bad) begin
                unique case (rd_idx)
                    `TPC_IDX_GSC: begin
                        n.rdata = {r.counter_overflow_flag, r.overflow_irq_enable, r.center_aligned_select, r.clks, r.ps};
                        if (r.counter_overflow_flag) begin
                            n.tof_arm = 1'b1;
                        end
                    end
                    `TPC_IDX_CNTH, `TPC_IDX_CNTL: begin
                        if (r.clat) begin
                            n.rdata = rd_hi ? r.cbuf[15:8] : r.cbuf[7:0];
                        end else begin
                            n.rdata = rd_hi ? r.cnt[15:8] : r.cnt[7:0];
                        end
                        // Latch state is left alone while debug holds the core
                        if (!bgnd_active) begin
                            if (!r.clat) begin
                                n.cbuf    = r.cnt;
                                n.clat    = 1'b1;
                                n.clat_hi = rd_hi;
                            end else if (r.clat_hi != rd_hi) begin
                                n.clat = 1'b0;
                            end
                        end
                    end
                    `TPC_IDX_MODH: n.rdata = r.mod[15:8];
                    `TPC_IDX_MODL: n.rdata = r.mod[7:0];
                    `TPC_IDX_CSC: begin
                        n.rdata = {r.chf, r.chie, r.msb, r.msa, r.els, 2'h0};
                        if (r.chf) begin
                            n.chf_arm = 1'b1;
                        end
                    end
                    `TPC_IDX_CVH: n.rdata = r.chval[15:8];
                    `TPC_IDX_CVL: n.rdata = r.chval[7:0];
                endcase
            end
        end
        // Events come last so a set beats a clear in the same cycle
        if (ovf_evt && !r.mod_pend) begin
            n.counter_overflow_flag     = 1'b1;
            n.tof_arm = 1'b0;
        end
        if (ch_evt) begin
            n.chf     = 1'b1;
            n.chf_arm = 1'b0;
            if (mode == tpc_mode_ic) begin
                n.chval = r.cnt;
            end
        end
        if (r.els != `TPC_ELS_OFF) begin
            if (ovf_evt && mode == tpc_mode_epwm) begin
                n.pin_out = ~r.els[0];
            end
            if (match_evt) begin
                unique case (mode)
                    tpc_mode_ic: n.pin_out = r.pin_out;
                    tpc_mode_oc: begin
                        unique case (r.els)
                            `TPC_ELS_RISE: n.pin_out = ~r.pin_out;
                            `TPC_ELS_FALL: n.pin_out = 1'b0;
                            `TPC_ELS_BOTH: n.pin_out = 1'b1;
                            `TPC_ELS_OFF:  n.pin_out = r.pin_out;
                        endcase
                    end
                    tpc_mode_epwm: n.pin_out = r.els[0];
                    tpc_mode_cpwm: n.pin_out = down_nx ? ~r.els[0] : r.els[0];
                endcase
            end
        end
    end

    // All-zero reset: counter, modulo, flags and enables clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    property p_clk_off;
        @(posedge aclk) disable iff (!aresetn)
        (r.clks == `TPC_CLKS_OFF && !wr_fire) |=> $stable(r.cnt);
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("counter moved with no clock source");

    property p_div;
        @(posedge aclk) disable iff (!aresetn)
        (tmr_tick && r.ps != 3'h0 && !wr_fire) |=> !tmr_tick;
    endproperty
    a_div: assert property (p_div) else $error("prescaled tick on consecutive cycles");

    property p_latch;
        @(posedge aclk) disable iff (!aresetn)
        (rd_fire && !rd_bad && (rd_hi || rd_idx == `TPC_IDX_CNTL) && !r.clat && !bgnd_active)
        |=> (r.clat && r.cbuf == $past(r.cnt));
    endproperty
    a_latch: assert property (p_latch) else $error("counter read did not latch both bytes");

    property p_cnt_wr;
        @(posedge aclk) disable iff (!aresetn)
        (wr_en && (r.aw_idx == `TPC_IDX_CNTH || r.aw_idx == `TPC_IDX_CNTL)) |=> (!r.clat && r.cnt == 16'h0000);
    endproperty
    a_cnt_wr: assert property (p_cnt_wr) else $error("counter write did not release latch");

    property p_bgnd;
        @(posedge aclk) disable iff (!aresetn)
        (bgnd_active && !wr_fire) |=> ($stable(r.cnt) && $stable(r.clat));
    endproperty
    a_bgnd: assert property (p_bgnd) else $error("debug did not freeze counter");

    property p_wrap;
        @(posedge aclk) disable iff (!aresetn)
        (tmr_tick && !r.center_aligned_select && r.cnt == term && !wr_fire) |=> (r.cnt == 16'h0000);
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not restart at terminal");

    property p_mod_pend;
        @(posedge aclk) disable iff (!aresetn)
        (r.mod_pend && !r.counter_overflow_flag) |=> !r.counter_overflow_flag;
    endproperty
    a_mod_pend: assert property (p_mod_pend) else $error("overflow set with modulo half written");

    property p_set_wins;
        @(posedge aclk) disable iff (!aresetn)
        (r.chf_arm && ch_evt) |=> (r.chf && !r.chf_arm);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost during clear sequence");

    property p_one_keeps;
        @(posedge aclk) disable iff (!aresetn)
        (wr_en && r.aw_idx == `TPC_IDX_CSC && r.w_data[`TPC_BIT_FLAG] && r.chf) |=> r.chf;
    endproperty
    a_one_keeps: assert property (p_one_keeps) else $error("writing one cleared channel flag");

    property p_gpio;
        @(posedge aclk) disable iff (!aresetn)
        (r.els == `TPC_ELS_OFF) |-> !ch_pin_oe;
    endproperty
    a_gpio: assert property (p_gpio) else $error("pin driven with edge/level off");
endmodule

// *** core/tpc_defs.svh ***
// Register indices, field positions, codes and reset values of the timer core
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH

`define TPC_IDX_GSC     3'h0
`define TPC_IDX_CNTH    3'h1
`define TPC_IDX_CNTL    3'h2
`define TPC_IDX_MODH    3'h3
`define TPC_IDX_MODL    3'h4
`define TPC_IDX_CSC     3'h5
`define TPC_IDX_CVH     3'h6
`define TPC_IDX_CVL     3'h7

`define TPC_BIT_FLAG    7
`define TPC_BIT_IE      6
`define TPC_BIT_CPWM    5
`define TPC_BIT_MSB     5
`define TPC_BIT_MSA     4
`define TPC_CLKS_HI     4
`define TPC_CLKS_LO     3
`define TPC_PS_HI       2
`define TPC_ELS_HI      3
`define TPC_ELS_LO      2

`define TPC_CLKS_OFF    2'h0
`define TPC_CLKS_BUS    2'h1
`define TPC_CLKS_FIX    2'h2
`define TPC_CLKS_EXT    2'h3

`define TPC_ELS_OFF     2'h0
`define TPC_ELS_RISE    2'h1
`define TPC_ELS_FALL    2'h2
`define TPC_ELS_BOTH    2'h3

`define TPC_RESP_OKAY   2'h0
`define TPC_RESP_SLVERR 2'h2

`define TPC_MOD_RST     16'h0000
`define TPC_CNT_FULL    16'hffff
`define TPC_CNT_ZERO    16'h0000

`endif

// *** core/tpc_pkg.sv ***
// Types shared by the timer core files
package tpc_pkg;

    typedef enum logic [1:0] {
        tpc_mode_ic,
        tpc_mode_oc,
        tpc_mode_epwm,
        tpc_mode_cpwm
    } tpc_mode_t;

    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] sync;
        logic [1:0] prev;
    } tpc_sync_t;

    typedef struct packed {
        logic        aw_have;
        logic        aw_bad;
        logic [2:0]  aw_idx;
        logic        w_have;
        logic [7:0]  w_data;
        logic        w_lane;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [7:0]  rdata;
        logic        counter_overflow_flag;
        logic        tof_arm;
        logic        overflow_irq_enable;
        logic        center_aligned_select;
        logic [1:0]  clks;
        logic [2:0]  ps;
        logic [6:0]  pre;
        logic [15:0] cnt;
        logic        down;
        logic [15:0] cbuf;
        logic        clat;
        logic        clat_hi;
        logic [15:0] mod;
        logic        mod_pend;
        logic        mod_hi;
        logic        chf;
        logic        chf_arm;
        logic        chie;
        logic        msb;
        logic        msa;
        logic [1:0]  els;
        logic [15:0] chval;
        logic        pin_prev;
        logic        pin_out;
    } tpc_state_t;

endpackage

// *** verif/tb.sv ***
// Self-checking bench of the timer core
`timescale 1ns/10ps
`include "tpc_defs.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
    import tpc_pkg::*;
    typedef struct packed {
        logic        w;
        logic [11:0] a;
        logic [7:0]  d;
        logic [7:0]  x;
        logic [1:0]  r;
    } tpc_row_t;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, bgnd_active, ext_clk_in, ext_run;
    logic        ch_pin_in, pin_lvl, ch_pin_out, ch_pin_oe, ch_irq, ovf_irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, wresp, rrsp;
    logic [7:0]  rdv, h1;
    logic [15:0] v0, v1;
    int          cyc, mismatches, num_checks;
    localparam tpc_row_t rows[10] = '{
        '{0, 12'h000, 8'h00, 8'h00, 2'h0}, '{0, 12'h008, 8'h00, 8'h00, 2'h0},
        '{0, 12'h010, 8'h00, 8'h00, 2'h0}, '{0, 12'h014, 8'h00, 8'h00, 2'h0},
        '{1, 12'h00c, 8'h12, 8'h12, 2'h0}, '{1, 12'h010, 8'h34, 8'h34, 2'h0},
        '{1, 12'h014, 8'hff, 8'h7c, 2'h0}, '{1, 12'h004, 8'hab, 8'h00, 2'h0},
        '{1, 12'h020, 8'h5a, 8'h00, `TPC_RESP_SLVERR}, '{1, 12'h01c, 8'h56, 8'h56, 2'h0}};

    tpc_core u_tpc_core (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .bgnd_active(bgnd_active), .ext_clk_in(ext_clk_in),
        .fixed_clk_in(cyc[2]), .ch_pin_in(ch_pin_in), .ch_pin_out(ch_pin_out),
        .ch_pin_oe(ch_pin_oe), .ch_irq(ch_irq), .ovf_irq(ovf_irq));
    tpc_pin_model u_tpc_pin_model (.aclk(aclk), .ext_run(ext_run), .pin_lvl(pin_lvl),
        .ext_clk_in(ext_clk_in), .ch_pin_in(ch_pin_in));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) cyc <= cyc + 1;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 40);
        // Ready stays high so back-to-back calls never drive it twice in one step
        wresp = bresp;
        if (n >= 40) begin
            mismatches++;
            finish_test();
        end
    endtask

    task automatic rd(input logic [11:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 40);
        rdv = rdata[7:0];
        rrsp = rresp;
        if (n >= 40) begin
            mismatches++;
            finish_test();
        end
    endtask

    task automatic cnt(output logic [15:0] v);
        rd(12'h004);
        v[15:8] = rdv;
        rd(12'h008);
        v[7:0] = rdv;
    endtask

    // Equal spacing of both latches makes the delta exact
    task automatic rate(input logic [1:0] cs, input logic [2:0] ps, input int e);
        int t0;
        wr(12'h000, {3'h0, cs, ps});
        t0 = cyc;
        cnt(v0);
        while (cyc < t0 + 512) @(posedge aclk);
        cnt(v1);
        `CHK("count", e[15:0], v1 - v0)
    endtask

    task automatic cap(input logic [1:0] el, input logic lv, input logic e);
        rd(12'h014);
        wr(12'h014, {4'h4, el, 2'h0});
        pin_lvl <= lv;
        repeat (8) @(posedge aclk);
        rd(12'h014);
        `CHK("flag", e, rdv[7])
        `CHK("ch_irq", e, ch_irq)
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, bgnd_active, ext_run, pin_lvl} = '0;
        {awaddr, araddr, wdata, cyc, mismatches, num_checks} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d);
                `CHK("bresp", rows[i].r, wresp)
            end
            rd(rows[i].a);
            `CHK("rdata", rows[i].x, rdv)
            `CHK("rresp", rows[i].r, rrsp)
        end
        $display("test rows done");
        wr(12'h014, 8'h00);
        wr(12'h00c, 8'h00);
        wr(12'h010, 8'h00);
        ext_run <= 1'b1;
        for (int p = 0; p < 8; p++) rate(2'h1, p[2:0], 512 >> p);
        rate(2'h0, 3'h0, 0);
        rate(2'h2, 3'h0, 64);
        rate(2'h3, 3'h0, 128);
        ext_run <= 1'b0;
        $display("test clock rates done");
        wr(12'h000, 8'h08);
        rd(12'h004);
        h1 = rdv;
        repeat (300) @(posedge aclk);
        rd(12'h004);
        `CHK("latched", h1, rdv)
        // Release first so reads in debug see the live counter, not the latch
        wr(12'h000, 8'h08);
        bgnd_active <= 1'b1;
        cnt(v0);
        repeat (300) @(posedge aclk);
        cnt(v1);
        `CHK("frozen", v0, v1)
        bgnd_active <= 1'b0;
        rd(12'h004);
        wr(12'h008, 8'h00);
        rd(12'h004);
        `CHK("released", 8'h00, rdv)
        $display("test coherency done");
        // Low byte alone opens the pair; terminal 0x10 is passed while open
        wr(12'h000, 8'h00);
        wr(12'h010, 8'h10);
        wr(12'h008, 8'h00);
        wr(12'h000, 8'h08);
        repeat (60) @(posedge aclk);
        rd(12'h000);
        `CHK("half modulo", 8'h08, rdv)
        wr(12'h00c, 8'h00);
        repeat (40) @(posedge aclk);
        rd(12'h000);
        `CHK("overflow", 8'h88, rdv)
        cnt(v0);
        `CHK("wrapped", 1'b1, v0 <= 16'h0010)
        wr(12'h000, 8'h80);
        wr(12'h000, 8'h40);
        rd(12'h000);
        `CHK("unarmed", 8'hc0, rdv)
        `CHK("ovf_irq", 1'b1, ovf_irq)
        wr(12'h000, 8'h40);
        rd(12'h000);
        `CHK("cleared", 8'h40, rdv)
        $display("test overflow done");
        for (int e = 1; e < 4; e++) begin
            cap(e[1:0], 1'b1, e[0]);
            cap(e[1:0], 1'b0, e[1]);
        end
        pin_lvl <= 1'b1;
        repeat (8) @(posedge aclk);
        wr(12'h014, 8'h4c);
        rd(12'h014);
        `CHK("kept", 1'b1, rdv[7])
        wr(12'h014, 8'hcc);
        rd(12'h014);
        `CHK("one kept", 1'b1, rdv[7])
        wr(12'h014, 8'h50);
        `CHK("pin_oe", 1'b0, ch_pin_oe)
        $display("test channel done");
        wr(12'h000, 8'h28);
        repeat (40) @(posedge aclk);
        rd(12'h000);
        `CHK("center overflow", 8'ha8, rdv)
        wr(12'h018, 8'h00);
        wr(12'h01c, 8'h05);
        wr(12'h000, 8'h08);
        // Set, clear, set again so the reset below meets a driven high pin
        for (int k = 0; k < 3; k++) begin
            wr(12'h014, k[0] ? 8'h18 : 8'h1c);
            repeat (40) @(posedge aclk);
            `CHK("ch_pin_out", !k[0], ch_pin_out)
        end
        `CHK("pin_oe on", 1'b1, ch_pin_oe)
        $display("test pin done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK("reset oe", 1'b0, ch_pin_oe)
        cnt(v0);
        `CHK("reset count", 16'h0000, v0)
        rd(12'h014);
        `CHK("reset channel", 8'h00, rdv)
        $display("test reset done");
        finish_test();
    end
endmodule

// *** verif/tpc_pin_model.sv ***
// Far-side model: external timer clock source and channel pin
`timescale 1ns/10ps
module tpc_pin_model (
    input  wire logic aclk,
    input  wire logic ext_run,
    input  wire logic pin_lvl,
    output logic      ext_clk_in,
    output logic      ch_pin_in
);
    logic [1:0] div_reg = 2'h0;
    always @(posedge aclk) begin
        div_reg <= ext_run ? div_reg + 2'h1 : 2'h0;
    end
    // Quarter bus rate; held low when not running
    assign ext_clk_in = ext_run & div_reg[1];
    assign ch_pin_in  = pin_lvl;
endmodule
